// *** design/cies_core.sv ***
`timescale 1ns/100ps
`include "cies_regs.svh"
module cies_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Program memory
    output logic [`CIES_PCW-1:0] pm_addr_q,
    output logic pm_rd_q,
    input wire cies_pkg::cies_instr_s pm_instr,
    // Data memory
    output logic [`CIES_DW-1:0] dm_addr_q,
    output logic dm_rd_q,
    output logic dm_wr_q,
    output logic [`CIES_DW-1:0] dm_wdata_q,
    input wire logic [`CIES_DW-1:0] dm_rdata,
    // Call logic pushing return addresses
    input wire logic push_req,
    input wire logic [`CIES_PCW-1:0] push_pc,
    // Watchdog, power and interrupt
    input wire logic wdt_timeout,
    input wire logic wake_pin,
    output logic wdt_clr_q,
    output logic clk_stop_q,
    output logic pdf_q,
    output logic to_q,
    output logic emi_q,
    // Core state
    output logic [`CIES_DW-1:0] work_register_q,
    output cies_pkg::cies_flags_s flags_q
);
    cies_pkg::cies_core_s s_q;
    cies_pkg::cies_core_s s_d;
    cies_pkg::cies_alu_s sub_borrow;
    logic [`CIES_PCW-1:0] stk_rd;
    logic pop;
    logic [`CIES_DW-1:0] opnd;
    logic [`CIES_DW-1:0] adj;
    logic [`CIES_DW:0] bcd_sum;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic zero_f(input logic [`CIES_DW-1:0] v);
        return v == `CIES_DW'h00;
    endfunction

    function automatic logic imm_f(input cies_pkg::cies_op_e op);
        return op inside {cies_pkg::OP_MOV_WI, cies_pkg::OP_OR_I, cies_pkg::OP_SBC_I, cies_pkg::OP_RET_I};
    endfunction

    function automatic logic needs_mem_f(input cies_pkg::cies_op_e op);
        return !(imm_f(op) || op inside {cies_pkg::OP_NOP, cies_pkg::OP_BCD, cies_pkg::OP_HALT,
            cies_pkg::OP_JMP, cies_pkg::OP_MOV_MW, cies_pkg::OP_RET, cies_pkg::OP_IRQ_EXIT});
    endfunction

    function automatic cies_pkg::cies_alu_s sbc_f(input logic [`CIES_DW-1:0] a,
                                                   input logic [`CIES_DW-1:0] b,
                                                   input cies_pkg::cies_flags_s f);
        cies_pkg::cies_alu_s o;
        logic [`CIES_DW:0] full;
        logic [4:0] low;
        full = {1'b0, a} - {1'b0, b} - {`CIES_DW'h00, ~f.c};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~f.c};
        o.res = full[`CIES_DW-1:0];
        o.f.c = ~full[`CIES_DW];
        o.f.ac = ~low[4];
        o.f.ov = (a[7] ^ b[7]) & (a[7] ^ o.res[7]);
        o.f.z = zero_f(o.res);
        o.f.sc = o.res[7] ^ o.f.ov;
        o.f.cz = o.f.z & f.cz;
        return o;
    endfunction

    cies_stack u_stack (
        .clk(clk),
        .rst(rst),
        .push(push_req),
        .push_data(push_pc),
        .pop(pop),
        .rd_q(stk_rd)
    );

    // ------------------------------------------------------------
    // Sequencer and execution
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        pop = 1'b0;
        opnd = imm_f(s_q.ir.op) ? s_q.ir.arg : dm_rdata;
        sub_borrow = sbc_f(s_q.acc, opnd, s_q.f);
        adj = {((s_q.acc[7:4] > `CIES_BCD_LIMIT) || s_q.f.c) ? `CIES_BCD_STEP : 4'h0,
               ((s_q.acc[3:0] > `CIES_BCD_LIMIT) || s_q.f.ac) ? `CIES_BCD_STEP : 4'h0};
        bcd_sum = {1'b0, s_q.acc} + {1'b0, adj};
        s_d.wake_s1 = wake_pin;
        s_d.wake_s2 = s_q.wake_s1;
        s_d.pm_rd = 1'b0;
        s_d.dm_rd = 1'b0;
        s_d.dm_wr = 1'b0;
        s_d.wdt_clr = 1'b0;
        if (wdt_timeout) begin
            s_d.to = 1'b1;
        end
        unique case (s_q.state)
            cies_pkg::ST_FETCH: begin
                s_d.state = cies_pkg::ST_DECODE;
            end
            cies_pkg::ST_DECODE: begin
                s_d.ir = pm_instr;
                s_d.pc = s_q.pc + `CIES_PCW'(1);
                s_d.dm_addr = pm_instr.arg;
                s_d.dm_rd = needs_mem_f(pm_instr.op);
                pop = pm_instr.op inside {cies_pkg::OP_RET, cies_pkg::OP_RET_I, cies_pkg::OP_IRQ_EXIT};
                s_d.state = cies_pkg::ST_READ;
            end
            cies_pkg::ST_READ: begin
                s_d.state = cies_pkg::ST_EXEC;
            end
            cies_pkg::ST_EXEC: begin
                s_d.state = cies_pkg::ST_FETCH;
                s_d.pm_rd = 1'b1;
                case (s_q.ir.op)
                    cies_pkg::OP_BCD: begin
                        s_d.dm_wr = 1'b1;
                        s_d.dm_wdata = bcd_sum[`CIES_DW-1:0];
                        s_d.f.c = s_q.f.c | bcd_sum[`CIES_DW];
                    end
                    cies_pkg::OP_DEC_M, cies_pkg::OP_INC_M: begin
                        s_d.dm_wr = 1'b1;
                        s_d.dm_wdata = (s_q.ir.op == cies_pkg::OP_INC_M) ? dm_rdata + `CIES_DW'(1)
                                                                          : dm_rdata - `CIES_DW'(1);
                        s_d.f.z = zero_f(s_d.dm_wdata);
                    end
                    cies_pkg::OP_DEC_W, cies_pkg::OP_INC_W: begin
                        s_d.acc = (s_q.ir.op == cies_pkg::OP_INC_W) ? dm_rdata + `CIES_DW'(1)
                                                                     : dm_rdata - `CIES_DW'(1);
                        s_d.f.z = zero_f(s_d.acc);
                    end
                    cies_pkg::OP_HALT: begin
                        s_d.state = cies_pkg::ST_HALT;
                        s_d.pm_rd = 1'b0;
                        s_d.clk_stop = 1'b1;
                        s_d.wdt_clr = 1'b1;
                        s_d.power_down_flag = 1'b1;
                        s_d.to = 1'b0;
                    end
                    cies_pkg::OP_JMP: begin
                        s_d.pc = s_q.ir.target;
                        s_d.state = cies_pkg::ST_DUMMY;
                        s_d.pm_rd = 1'b0;
                    end
                    cies_pkg::OP_MOV_WM, cies_pkg::OP_MOV_WI: begin
                        s_d.acc = opnd;
                    end
                    cies_pkg::OP_MOV_MW: begin
                        s_d.dm_wr = 1'b1;
                        s_d.dm_wdata = s_q.acc;
                    end
                    cies_pkg::OP_OR_M, cies_pkg::OP_OR_I: begin
                        s_d.acc = s_q.acc | opnd;
                        s_d.f.z = zero_f(s_d.acc);
                    end
                    cies_pkg::OP_ORM: begin
                        s_d.dm_wr = 1'b1;
                        s_d.dm_wdata = s_q.acc | dm_rdata;
                        s_d.f.z = zero_f(s_d.dm_wdata);
                    end
                    cies_pkg::OP_RET, cies_pkg::OP_RET_I, cies_pkg::OP_IRQ_EXIT: begin
                        s_d.pc = stk_rd;
                        s_d.state = cies_pkg::ST_DUMMY;
                        s_d.pm_rd = 1'b0;
                        if (s_q.ir.op == cies_pkg::OP_RET_I) begin
                            s_d.acc = s_q.ir.arg;
                        end
                        if (s_q.ir.op == cies_pkg::OP_IRQ_EXIT) begin
                            s_d.global_irq_enable = 1'b1;
                        end
                    end
                    cies_pkg::OP_RL, cies_pkg::OP_RLA: begin
                        if (s_q.ir.op == cies_pkg::OP_RL) begin
                            s_d.dm_wr = 1'b1;
                            s_d.dm_wdata = {dm_rdata[6:0], dm_rdata[7]};
                        end else begin
                            s_d.acc = {dm_rdata[6:0], dm_rdata[7]};
                        end
                    end
                    cies_pkg::OP_RLC, cies_pkg::OP_ROT_LEFT_VIA_CY_TO_W: begin
                        s_d.f.c = dm_rdata[7];
                        if (s_q.ir.op == cies_pkg::OP_RLC) begin
                            s_d.dm_wr = 1'b1;
                            s_d.dm_wdata = {dm_rdata[6:0], s_q.f.c};
                        end else begin
                            s_d.acc = {dm_rdata[6:0], s_q.f.c};
                        end
                    end
                    cies_pkg::OP_RR, cies_pkg::OP_RRA: begin
                        if (s_q.ir.op == cies_pkg::OP_RR) begin
                            s_d.dm_wr = 1'b1;
                            s_d.dm_wdata = {dm_rdata[0], dm_rdata[7:1]};
                        end else begin
                            s_d.acc = {dm_rdata[0], dm_rdata[7:1]};
                        end
                    end
                    cies_pkg::OP_RRC, cies_pkg::OP_ROT_RIGHT_VIA_CY_TO_W: begin
                        s_d.f.c = dm_rdata[0];
                        if (s_q.ir.op == cies_pkg::OP_RRC) begin
                            s_d.dm_wr = 1'b1;
                            s_d.dm_wdata = {s_q.f.c, dm_rdata[7:1]};
                        end else begin
                            s_d.acc = {s_q.f.c, dm_rdata[7:1]};
                        end
                    end
                    cies_pkg::OP_SBC_M, cies_pkg::OP_SBC_I: begin
                        s_d.acc = sub_borrow.res;
                        s_d.f = sub_borrow.f;
                    end
                    cies_pkg::OP_SUB_BORROW_TO_MEM: begin
                        s_d.dm_wr = 1'b1;
                        s_d.dm_wdata = sub_borrow.res;
                        s_d.f = sub_borrow.f;
                    end
                    cies_pkg::OP_SDZ: begin
                        s_d.dm_wr = 1'b1;
                        s_d.dm_wdata = dm_rdata - `CIES_DW'(1);
                        if (zero_f(s_d.dm_wdata)) begin
                            s_d.pc = s_q.pc + `CIES_PCW'(1);
                        end
                        s_d.state = cies_pkg::ST_DUMMY;
                        s_d.pm_rd = 1'b0;
                    end
                    default: begin
                        s_d.acc = s_q.acc;
                    end
                endcase
            end
            cies_pkg::ST_DUMMY: begin
                s_d.state = cies_pkg::ST_FETCH;
                s_d.pm_rd = 1'b1;
            end
            cies_pkg::ST_HALT: begin
                if (s_q.wake_s2) begin
                    s_d.state = cies_pkg::ST_FETCH;
                    s_d.clk_stop = 1'b0;
                    s_d.pm_rd = 1'b1;
                end
            end
            default: begin
                s_d.state = cies_pkg::ST_FETCH;
                s_d.pm_rd = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.state <= cies_pkg::ST_FETCH;
            s_q.pc <= `CIES_PC_RST;
            s_q.pm_rd <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign pm_addr_q = s_q.pc;
    assign pm_rd_q = s_q.pm_rd;
    assign dm_addr_q = s_q.dm_addr;
    assign dm_rd_q = s_q.dm_rd;
    assign dm_wr_q = s_q.dm_wr;
    assign dm_wdata_q = s_q.dm_wdata;
    assign wdt_clr_q = s_q.wdt_clr;
    assign clk_stop_q = s_q.clk_stop;
    assign pdf_q = s_q.power_down_flag;
    assign to_q = s_q.to;
    assign emi_q = s_q.global_irq_enable;
    assign work_register_q = s_q.acc;
    assign flags_q = s_q.f;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic ex;
    assign ex = s_q.state == cies_pkg::ST_EXEC;

    AST_BRANCH: assert property (ex && s_q.ir.op == cies_pkg::OP_JMP |=>
        s_q.pc == s_q.ir.target ##1 s_q.state == cies_pkg::ST_FETCH && s_q.f == $past(s_q.f, 2))
        else $error("branch target or timing wrong");
    AST_POWER_DOWN: assert property (ex && s_q.ir.op == cies_pkg::OP_HALT |=>
        pdf_q && !to_q && clk_stop_q && wdt_clr_q && !pm_rd_q)
        else $error("power down effects missing");
    AST_DEC_MEM: assert property (ex && s_q.ir.op == cies_pkg::OP_DEC_M |=>
        dm_wr_q && dm_wdata_q == $past(dm_rdata) - 8'h01 && flags_q.z == (dm_wdata_q == 8'h00))
        else $error("decrement in place wrong");
    AST_INC_W: assert property (ex && s_q.ir.op == cies_pkg::OP_INC_W |=>
        !dm_wr_q && work_register_q == $past(dm_rdata) + 8'h01 && flags_q.c == $past(flags_q.c))
        else $error("increment to work register wrong");
    AST_COPY: assert property (ex && s_q.ir.op == cies_pkg::OP_MOV_MW |=>
        dm_wr_q && dm_wdata_q == work_register_q && $stable(flags_q))
        else $error("copy to memory wrong");
    AST_ROT_LEFT: assert property (ex && s_q.ir.op == cies_pkg::OP_RLA |=>
        work_register_q == {$past(dm_rdata[6:0]), $past(dm_rdata[7])} && $stable(flags_q))
        else $error("rotate left wrong");
    AST_ROT_RIGHT_CY: assert property (ex && s_q.ir.op == cies_pkg::OP_RRC |=>
        flags_q.c == $past(dm_rdata[0]) && dm_wdata_q[7] == $past(flags_q.c))
        else $error("rotate right through carry wrong");
    AST_BORROW_CARRY: assert property (ex && s_q.ir.op == cies_pkg::OP_SBC_I |=>
        flags_q.c == ({1'b0, $past(s_q.acc)} >= {1'b0, $past(s_q.ir.arg)} + {8'h00, ~$past(flags_q.c)}))
        else $error("borrow carry wrong");
    AST_SKIP: assert property (ex && s_q.ir.op == cies_pkg::OP_SDZ && dm_rdata == 8'h01 |=>
        pm_addr_q == $past(pm_addr_q) + 12'h001 && s_q.state == cies_pkg::ST_DUMMY)
        else $error("skip on zero wrong");
    AST_IRQ_EXIT: assert property (ex && s_q.ir.op == cies_pkg::OP_IRQ_EXIT |=>
        emi_q && pm_addr_q == $past(stk_rd))
        else $error("interrupt return wrong");

    COV_BRANCH: cover property (ex && s_q.ir.op == cies_pkg::OP_JMP);
    COV_HALT_WAKE: cover property (s_q.state == cies_pkg::ST_HALT ##[1:20] s_q.state == cies_pkg::ST_FETCH);
    COV_SKIP: cover property (ex && s_q.ir.op == cies_pkg::OP_SDZ && dm_rdata == 8'h01);
    COV_SUB_BORROW_TO_MEM: cover property (ex && s_q.ir.op == cies_pkg::OP_SUB_BORROW_TO_MEM);
endmodule

// *** design/cies_regs.svh ***
`ifndef CIES_REGS_SVH
`define CIES_REGS_SVH

`define CIES_DW 8
`define CIES_PCW 12
`define CIES_STK_DEPTH 8
`define CIES_STK_AW 3
`define CIES_PC_RST 12'h000
`define CIES_BCD_LIMIT 4'h9
`define CIES_BCD_STEP 4'h6

`endif

// *** design/cies_pkg.sv ***
`include "cies_regs.svh"
package cies_pkg;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_BCD = 5'h01, OP_DEC_M = 5'h02, OP_INC_M = 5'h03,
        OP_DEC_W = 5'h04, OP_INC_W = 5'h05, OP_HALT = 5'h06, OP_JMP = 5'h07,
        OP_MOV_WM = 5'h08, OP_MOV_WI = 5'h09, OP_MOV_MW = 5'h0A, OP_OR_M = 5'h0B,
        OP_OR_I = 5'h0C, OP_ORM = 5'h0D, OP_RET = 5'h0E, OP_RET_I = 5'h0F,
        OP_IRQ_EXIT = 5'h10, OP_RL = 5'h11, OP_RLA = 5'h12, OP_RLC = 5'h13,
        OP_ROT_LEFT_VIA_CY_TO_W = 5'h14, OP_RR = 5'h15, OP_RRA = 5'h16, OP_RRC = 5'h17,
        OP_ROT_RIGHT_VIA_CY_TO_W = 5'h18, OP_SBC_M = 5'h19, OP_SBC_I = 5'h1A, OP_SUB_BORROW_TO_MEM = 5'h1B,
        OP_SDZ = 5'h1C
    } cies_op_e;

    typedef struct packed {
        cies_op_e op;
        logic [`CIES_DW-1:0] arg;
        logic [`CIES_PCW-1:0] target;
    } cies_instr_s;

    typedef struct packed {
        logic c;
        logic ac;
        logic z;
        logic ov;
        logic sc;
        logic cz;
    } cies_flags_s;

    typedef struct packed {
        logic [`CIES_DW-1:0] res;
        cies_flags_s f;
    } cies_alu_s;

    typedef enum logic [5:0] {
        ST_FETCH = 6'h01, ST_DECODE = 6'h02, ST_READ = 6'h04,
        ST_EXEC = 6'h08, ST_DUMMY = 6'h10, ST_HALT = 6'h20
    } cies_state_e;

    typedef struct packed {
        cies_state_e state;
        logic [`CIES_PCW-1:0] pc;
        cies_instr_s ir;
        logic [`CIES_DW-1:0] acc;
        cies_flags_s f;
        logic global_irq_enable;
        logic power_down_flag;
        logic to;
        logic clk_stop;
        logic wdt_clr;
        logic pm_rd;
        logic dm_rd;
        logic dm_wr;
        logic [`CIES_DW-1:0] dm_addr;
        logic [`CIES_DW-1:0] dm_wdata;
        logic wake_s1;
        logic wake_s2;
    } cies_core_s;

    typedef struct packed {
        logic [`CIES_STK_DEPTH-1:0][`CIES_PCW-1:0] mem;
        logic [`CIES_STK_AW-1:0] ptr;
        logic [`CIES_PCW-1:0] rd;
    } cies_stack_s;

endpackage

// *** design/cies_stack.sv ***
`timescale 1ns/100ps
`include "cies_regs.svh"
module cies_stack (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Push side
    input wire logic push,
    input wire logic [`CIES_PCW-1:0] push_data,
    // Pop side
    input wire logic pop,
    output logic [`CIES_PCW-1:0] rd_q
);
    cies_pkg::cies_stack_s s_q;
    cies_pkg::cies_stack_s s_d;

    // ------------------------------------------------------------
    // Return-address store, pop wins over a simultaneous push
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (pop) begin
            s_d.ptr = s_q.ptr - `CIES_STK_AW'(1);
            s_d.rd = s_q.mem[s_q.ptr - `CIES_STK_AW'(1)];
        end else if (push) begin
            s_d.mem[s_q.ptr] = push_data;
            s_d.ptr = s_q.ptr + `CIES_STK_AW'(1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_q = s_q.rd;
endmodule

// *** tb/cies_mem.sv ***
`timescale 1ns/100ps
module cies_mem (
    // Clock
    input wire logic clk,
    // Program memory side
    input wire logic [11:0] pm_addr_q,
    input wire logic pm_rd_q,
    output cies_pkg::cies_instr_s pm_instr,
    // Data memory side
    input wire logic [7:0] dm_addr_q,
    input wire logic dm_rd_q,
    input wire logic dm_wr_q,
    input wire logic [7:0] dm_wdata_q,
    output logic [7:0] dm_rdata
);
    // ----
    // Storage and one-cycle answers
    // ----
    cies_pkg::cies_instr_s prog [4096];
    logic [7:0] ram [256];
    initial begin
        pm_instr = '0;
        dm_rdata = 8'h00;
    end
    // Outside the answer cycle both buses toggle, so a sample one cycle late sees inverted data
    always @(posedge clk) begin
        pm_instr <= pm_rd_q ? prog[pm_addr_q] : ~pm_instr;
        dm_rdata <= dm_rd_q ? ram[dm_addr_q] : ~dm_rdata;
        if (dm_wr_q) begin
            ram[dm_addr_q] <= dm_wdata_q;
        end
    end
endmodule

// *** tb/test_cpu_instruction_execute_subset.sv ***
`timescale 1ns/100ps
module test_cpu_instruction_execute_subset;
    // ----
    // Signals and harness
    // ----
    logic clk, rst, push_req, wdt_timeout, wake_pin, pm_rd_q, dm_rd_q, dm_wr_q, e_emi;
    logic wdt_clr_q, clk_stop_q, pdf_q, to_q, emi_q;
    logic [11:0] push_pc, pm_addr_q;
    logic [7:0] dm_addr_q, dm_wdata_q, dm_rdata, work_register_q, e_acc;
    cies_pkg::cies_instr_s pm_instr;
    cies_pkg::cies_flags_s flags_q, e_f;
    logic [11:0] stk [$];
    logic [12:0] cor [10] = '{13'h099A, 13'h0120, 13'h0600, 13'h0980, 13'h1A01, 13'h1A7F, 13'h1C10,
        13'h1C10, 13'h0F5A, 13'h1000};
    int err_count, n_compared, cyc, seed;
    cies_core u_dut (.clk(clk), .rst(rst), .pm_addr_q(pm_addr_q), .pm_rd_q(pm_rd_q), .pm_instr(pm_instr),
        .dm_addr_q(dm_addr_q), .dm_rd_q(dm_rd_q), .dm_wr_q(dm_wr_q), .dm_wdata_q(dm_wdata_q), .dm_rdata(dm_rdata),
        .push_req(push_req), .push_pc(push_pc), .wdt_timeout(wdt_timeout), .wake_pin(wake_pin),
        .wdt_clr_q(wdt_clr_q), .clk_stop_q(clk_stop_q), .pdf_q(pdf_q), .to_q(to_q), .emi_q(emi_q),
        .work_register_q(work_register_q), .flags_q(flags_q));
    cies_mem u_mem (.clk(clk), .pm_addr_q(pm_addr_q), .pm_rd_q(pm_rd_q), .pm_instr(pm_instr),
        .dm_addr_q(dm_addr_q), .dm_rd_q(dm_rd_q), .dm_wr_q(dm_wr_q), .dm_wdata_q(dm_wdata_q), .dm_rdata(dm_rdata));
    task automatic give_verdict;
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // Called in a fetch cycle; places the instruction, predicts, then waits for the next fetch
    task automatic run_op(input logic [4:0] op, input logic [7:0] arg, input logic [11:0] tgt, input logic pu);
        logic [11:0] p, np;
        logic [8:0] s;
        logic [7:0] m, r, b, a, wd, wa;
        logic [4:0] h;
        logic wr, w, clr, d;
        int n;
        cies_pkg::cies_flags_s f;
        p = pm_addr_q;
        u_mem.prog[p] = {op, arg, tgt};
        push_req = pu;
        push_pc = 12'($random(seed));
        if (pu) stk.push_back(push_pc);
        w = 0; clr = 0; n = 1; wd = 0; wa = 0; wr = 0; d = 0;
        @(posedge clk);
        #1 push_req = 0;
        wdt_timeout = 0;
        m = u_mem.ram[arg];
        a = e_acc; f = e_f; r = m; np = p + 1;
        b = (op == 5'h1A || op == 5'h0C) ? arg : m;
        case (op)
            5'h01: begin
                s = a + ((a[3:0] > 4'h9 || f.ac) ? 9'h006 : 9'h000) + ((a[7:4] > 4'h9 || f.c) ? 9'h060 : 9'h000);
                r = s[7:0]; e_f.c = f.c | s[8]; wr = 1;
            end
            5'h02, 5'h03: begin r = op[0] ? m + 1 : m - 1; e_f.z = (r == 0); wr = 1; end
            5'h04, 5'h05: begin e_acc = op[0] ? m + 1 : m - 1; e_f.z = (e_acc == 0); end
            5'h07: begin np = tgt; d = 1; end
            5'h08: e_acc = m;
            5'h09: e_acc = arg;
            5'h0A: begin r = a; wr = 1; end
            5'h0B, 5'h0C: begin e_acc = a | b; e_f.z = (e_acc == 0); end
            5'h0D: begin r = a | m; e_f.z = (r == 0); wr = 1; end
            5'h0E, 5'h0F, 5'h10: begin
                np = stk.pop_back(); d = 1;
                if (op == 5'h0F) e_acc = arg;
                if (op == 5'h10) e_emi = 1;
            end
            5'h11, 5'h12: r = {m[6:0], m[7]};
            5'h13, 5'h14: begin r = {m[6:0], f.c}; e_f.c = m[7]; end
            5'h15, 5'h16: r = {m[0], m[7:1]};
            5'h17, 5'h18: begin r = {f.c, m[7:1]}; e_f.c = m[0]; end
            5'h19, 5'h1A, 5'h1B: begin
                s = {1'b0, a} - b - !f.c; r = s[7:0]; h = {1'b0, a[3:0]} - b[3:0] - !f.c;
                e_f.c = !s[8]; e_f.ac = !h[4]; e_f.ov = (a[7] != b[7]) && (r[7] != a[7]); e_f.z = (r == 0);
                e_f.sc = r[7] ^ e_f.ov; e_f.cz = e_f.z & f.cz;
                if (op == 5'h1B) wr = 1; else begin e_acc = r; r = m; end
            end
            5'h1C: begin r = m - 1; wr = 1; d = 1; if (r == 0) np = p + 2; end
            default: ;
        endcase
        if (op inside {[5'h11:5'h18]}) begin
            if (op[0]) wr = 1; else begin e_acc = r; r = m; end
        end
        do begin
            @(posedge clk);
            #1 n++;
            if (dm_wr_q === 1'b1) begin w = 1; wd = dm_wdata_q; wa = dm_addr_q; end
            if (wdt_clr_q === 1'b1) clr = 1;
            if (clk_stop_q === 1'b1 && !wake_pin) begin
                chk({pdf_q, to_q}, 2'b10);
                wake_pin = 1;
            end
        end while (pm_rd_q !== 1'b1 && n < 30);
        wake_pin = 0;
        chk(n, (op == 5'h06) ? 7 : (d ? 5 : 4));
        if (op == 5'h06) chk(clr, 1'b1);
        chk(pm_addr_q, np);
        chk(work_register_q, e_acc);
        chk(flags_q, e_f);
        chk({w, wd, wa}, wr ? {1'b1, r, arg} : {1'b0, wd, wa});
        chk(emi_q, e_emi);
    endtask
    task automatic issue(input logic [4:0] op, input logic [7:0] arg, input logic [11:0] tgt);
        if (op inside {[5'h0E:5'h10]}) run_op(5'h00, 8'h00, 12'h000, 1);
        run_op(op, arg, tgt, 0);
    endtask
    // ----
    // Clock, watchdog and sequence
    // ----
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    initial begin
        seed = 23; rst = 1; push_req = 0; push_pc = 12'h000; wdt_timeout = 0; wake_pin = 0;
        e_acc = 8'h00; e_f = '0; e_emi = 0;
        for (int i = 0; i < 256; i++) u_mem.ram[i] = 8'($random(seed));
        u_mem.ram[8'h10] = 8'h01;
        repeat (20) @(posedge clk);
        #1 rst = 0;
        for (int i = 0; i < 10; i++) begin
            wdt_timeout = (i == 1);
            issue(cor[i][12:8], cor[i][7:0], 12'h0A5);
            if (i == 1) chk(to_q, 1'b1);
        end
        repeat (400) issue(5'($unsigned($random(seed)) % 29), 8'($random(seed)), 12'($random(seed)));
        give_verdict();
    end
endmodule
